// >>> include/btla_map.vh
// Constants for the bidirectional task list agent
// Assumes inclusion by bare name from the design file
`ifndef BTLA_MAP_VH
`define BTLA_MAP_VH
`define BTLA_MGT_LOGIN 4'h0
`define BTLA_MGT_QUERY 4'h1
`define BTLA_MGT_STREAM 4'h2
`define BTLA_MGT_RECONNECT 4'h3
`define BTLA_MGT_PASSWORD 4'h4
`define BTLA_MGT_LOGOUT 4'h7
`define BTLA_MGT_ABORT_TASK 4'hB
`define BTLA_MGT_ABORT_SET 4'hC
`define BTLA_MGT_CLEAR_SET 4'hD
`define BTLA_MGT_TARGET_RESET 4'hE
`define BTLA_MGT_LUN_RESET 4'hF
`define BTLA_ST_OK 8'h00
`define BTLA_ST_UNSUPPORTED 8'h01
`define BTLA_ST_REJECTED 8'h02
`define BTLA_ST_ILLEGAL 8'hFF
`define BTLA_RESP_OK 2'h0
`define BTLA_RESP_ILLEGAL 2'h2
`define BTLA_PAYLOAD_UNIT 32'h00000080
`define BTLA_PAYLOAD_UNIT_LOG2 7
`define BTLA_PAYLOAD_MAX_UNITS 25'h1000000
`define BTLA_CDB_BITS 96
`define BTLA_RECON_HOLD_US 1000000
`define BTLA_CLK_MHZ 40
`define BTLA_DIR_WRITE 1'b0
`define BTLA_DIR_READ 1'b1
`endif

// >>> hdl/btla_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
// Assumes a single clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module btla_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire clock,
    input wire resetn,
    input wire flush,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;
    integer i;
    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1)
                mem_reg[i] <= {WIDTH{1'b0}};
        end
        else if (flush)
        begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem_reg[wr_reg] <= in_data;
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop)
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/btla_agent.v
// Command block agent: one fetch agent, two direction queues, two executors
// Assumes a fetch engine outside presents task blocks; the bus reset pin is
// asynchronous to clock.
// What this block does
// - Device holds session across link interruptions
// - Buffers never exceed negotiated direction size
// - Fetch blocks in list order, inspect payload
// - Writes to write queue, reads to read
// - Two independent in-order execution agents
// - Status stored in each agent's finish order
// - No link pointer reads after queuing
// - Order kept per direction, not across
// - Task set size limit is configurable
// - At least one login supported
// - Command payload field is twelve bytes
// - Required management functions implemented; abort task ignores mgt_tag and flushes all tasks
// - Create stream, password, clear set unsupported
// - Payload sizes negotiated per direction, 128-byte units
// - Payload size capped at two to 31
// - Missing notify flag kills the agent
`timescale 1ns/1ps
`default_nettype none
`include "btla_map.vh"
module btla_agent #(
    parameter TAG_W = 8,
    parameter DEPTH = 4,
    parameter AW = 2,
    parameter RECON_CYCLES = `BTLA_RECON_HOLD_US * `BTLA_CLK_MHZ
) (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Bus reset from the serial bus, asynchronous
    input wire bus_reset_pin,
    // Configuration from negotiation
    input wire [7:0] rd_opcode,
    input wire [7:0] rd_opmask,
    input wire [7:0] max_task_set,
    input wire [24:0] max_units_wr,
    input wire [24:0] max_units_rd,
    // Task block presented by the fetch engine, in list order
    input wire task_valid,
    output reg task_ready,
    input wire [TAG_W-1:0] task_tag,
    input wire [`BTLA_CDB_BITS-1:0] task_cdb,
    input wire task_notify,
    input wire [31:0] task_len,
    output reg fetch_link_enable,
    // Management request
    input wire mgt_valid,
    input wire [3:0] mgt_function,
    input wire [TAG_W-1:0] mgt_tag,
    output reg mgt_done,
    output reg [7:0] mgt_status,
    // Write execution agent
    output reg wr_exec_valid,
    output reg [TAG_W-1:0] wr_exec_tag,
    input wire wr_exec_done,
    // Read execution agent
    output reg rd_exec_valid,
    output reg [TAG_W-1:0] rd_exec_tag,
    input wire rd_exec_done,
    // Completion status
    output reg stat_valid,
    output reg stat_dir,
    output reg [TAG_W-1:0] stat_tag,
    output reg [1:0] stat_resp,
    output reg [7:0] stat_code,
    // State
    output reg logged_in,
    output reg dead
);
    // ****************************************
    // Bus reset synchroniser
    // ****************************************
    reg [2:0] brst_sync_reg;
    reg brst_reg;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            brst_sync_reg <= 3'h0;
            brst_reg <= 1'b0;
        end
        else
        begin
            brst_sync_reg <= {brst_sync_reg[1:0], bus_reset_pin};
            if (brst_sync_reg[2] == brst_sync_reg[1])
                brst_reg <= brst_sync_reg[2];
        end
    end
    // ****************************************
    // Classification and limits
    // ****************************************
    wire [7:0] opcode = task_cdb[`BTLA_CDB_BITS-1 -: 8];
    wire is_read = ((opcode & rd_opmask) == (rd_opcode & rd_opmask));
    wire [24:0] lim_units = is_read ? max_units_rd : max_units_wr;
    wire [24:0] units_clip = (lim_units > `BTLA_PAYLOAD_MAX_UNITS) ?
        `BTLA_PAYLOAD_MAX_UNITS : lim_units;
    wire [31:0] len_units = task_len >> `BTLA_PAYLOAD_UNIT_LOG2;
    wire len_rem = |task_len[`BTLA_PAYLOAD_UNIT_LOG2-1:0];
    wire too_big = ({7'h00, units_clip} < len_units) ||
        (({7'h00, units_clip} == len_units) && len_rem);
    reg [7:0] outstanding_reg;
    reg flush_reg;
    wire room = outstanding_reg < max_task_set;
    // ****************************************
    // Direction queues
    // ****************************************
    wire wq_in_ready;
    wire rq_in_ready;
    wire wq_valid;
    wire rq_valid;
    wire [TAG_W-1:0] wq_tag;
    wire [TAG_W-1:0] rq_tag;
    wire take = task_valid && task_ready;
    wire bad = !task_notify || too_big;
    wire ok_stat_dec = stat_valid && (stat_resp == `BTLA_RESP_OK) && (outstanding_reg != 8'h00);
    wire wq_push = take && !bad && !is_read;
    wire rq_push = take && !bad && is_read;
    reg wr_busy_reg;
    reg rd_busy_reg;
    wire wq_pop = wq_valid && !wr_busy_reg && !dead;
    wire rq_pop = rq_valid && !rd_busy_reg && !dead;
    btla_fifo #(.WIDTH(TAG_W), .DEPTH(DEPTH), .AW(AW)) u_wq (
        .clock(clock),
        .resetn(resetn),
        .flush(flush_reg),
        .in_valid(wq_push),
        .in_ready(wq_in_ready),
        .in_data(task_tag),
        .out_valid(wq_valid),
        .out_ready(wq_pop),
        .out_data(wq_tag)
    );
    btla_fifo #(.WIDTH(TAG_W), .DEPTH(DEPTH), .AW(AW)) u_rq (
        .clock(clock),
        .resetn(resetn),
        .flush(flush_reg),
        .in_valid(rq_push),
        .in_ready(rq_in_ready),
        .in_data(task_tag),
        .out_valid(rq_valid),
        .out_ready(rq_pop),
        .out_data(rq_tag)
    );
    // ****************************************
    // Fetch, execute, status
    // ****************************************
    reg [31:0] recon_cnt_reg;
    reg wr_fin_reg;
    reg rd_fin_reg;
    wire acc_next = logged_in && !dead && !flush_reg && room && wq_in_ready && rq_in_ready;
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            task_ready <= 1'b0;
            fetch_link_enable <= 1'b0;
            wr_exec_valid <= 1'b0;
            wr_exec_tag <= {TAG_W{1'b0}};
            rd_exec_valid <= 1'b0;
            rd_exec_tag <= {TAG_W{1'b0}};
            wr_busy_reg <= 1'b0;
            rd_busy_reg <= 1'b0;
            wr_fin_reg <= 1'b0;
            rd_fin_reg <= 1'b0;
            stat_valid <= 1'b0;
            stat_dir <= `BTLA_DIR_WRITE;
            stat_tag <= {TAG_W{1'b0}};
            stat_resp <= `BTLA_RESP_OK;
            stat_code <= `BTLA_ST_OK;
            mgt_done <= 1'b0;
            mgt_status <= `BTLA_ST_OK;
            logged_in <= 1'b0;
            dead <= 1'b0;
            outstanding_reg <= 8'h00;
            flush_reg <= 1'b0;
            recon_cnt_reg <= 32'h00000000;
        end
        else
        begin
            flush_reg <= 1'b0;
            mgt_done <= 1'b0;
            stat_valid <= 1'b0;
            task_ready <= acc_next && !task_ready;
            fetch_link_enable <= acc_next && !take;
            if (wq_pop)
            begin
                wr_busy_reg <= 1'b1;
                wr_exec_valid <= 1'b1;
                wr_exec_tag <= wq_tag;
            end
            else if (wr_exec_done && wr_busy_reg)
            begin
                wr_exec_valid <= 1'b0;
                wr_busy_reg <= 1'b0;
                wr_fin_reg <= 1'b1;
            end
            if (rq_pop)
            begin
                rd_busy_reg <= 1'b1;
                rd_exec_valid <= 1'b1;
                rd_exec_tag <= rq_tag;
            end
            else if (rd_exec_done && rd_busy_reg)
            begin
                rd_exec_valid <= 1'b0;
                rd_busy_reg <= 1'b0;
                rd_fin_reg <= 1'b1;
            end
            // Illegal block takes the status port first; finishes wait
            if (take && bad)
            begin
                stat_valid <= 1'b1;
                stat_dir <= is_read;
                stat_tag <= task_tag;
                stat_resp <= `BTLA_RESP_ILLEGAL;
                stat_code <= `BTLA_ST_ILLEGAL;
                if (!task_notify)
                begin
                    dead <= 1'b1;
                    flush_reg <= 1'b1;
                end
            end
            else if (wr_fin_reg)
            begin
                wr_fin_reg <= 1'b0;
                stat_valid <= 1'b1;
                stat_dir <= `BTLA_DIR_WRITE;
                stat_tag <= wr_exec_tag;
                stat_resp <= `BTLA_RESP_OK;
                stat_code <= `BTLA_ST_OK;
            end
            else if (rd_fin_reg)
            begin
                rd_fin_reg <= 1'b0;
                stat_valid <= 1'b1;
                stat_dir <= `BTLA_DIR_READ;
                stat_tag <= rd_exec_tag;
                stat_resp <= `BTLA_RESP_OK;
                stat_code <= `BTLA_ST_OK;
            end
            if (take && !bad && !ok_stat_dec)
                outstanding_reg <= outstanding_reg + 8'h01;
            else if (ok_stat_dec && !(take && !bad))
                outstanding_reg <= outstanding_reg - 8'h01;
            // Bus reset aborts tasks; login held for the reconnect window
            if (brst_reg && logged_in)
            begin
                flush_reg <= 1'b1;
                outstanding_reg <= 8'h00;
                recon_cnt_reg <= RECON_CYCLES;
            end
            else if (recon_cnt_reg != 32'h00000000)
            begin
                recon_cnt_reg <= recon_cnt_reg - 32'h00000001;
                if (recon_cnt_reg == 32'h00000001)
                    logged_in <= 1'b0;
            end
            if (flush_reg)
            begin
                wr_busy_reg <= 1'b0;
                rd_busy_reg <= 1'b0;
                wr_exec_valid <= 1'b0;
                rd_exec_valid <= 1'b0;
                wr_fin_reg <= 1'b0;
                rd_fin_reg <= 1'b0;
                outstanding_reg <= 8'h00;
            end
            if (mgt_valid)
            begin
                mgt_done <= 1'b1;
                mgt_status <= `BTLA_ST_OK;
                case (mgt_function)
                    `BTLA_MGT_LOGIN:
                    begin
                        if (logged_in)
                            mgt_status <= `BTLA_ST_REJECTED;
                        else
                        begin
                            logged_in <= 1'b1;
                            dead <= 1'b0;
                            recon_cnt_reg <= 32'h00000000;
                        end
                    end
                    `BTLA_MGT_QUERY:
                        mgt_status <= `BTLA_ST_OK;
                    `BTLA_MGT_RECONNECT:
                    begin
                        if (recon_cnt_reg != 32'h00000000)
                            recon_cnt_reg <= 32'h00000000;
                        else
                            mgt_status <= `BTLA_ST_REJECTED;
                    end
                    `BTLA_MGT_LOGOUT:
                    begin
                        logged_in <= 1'b0;
                        flush_reg <= 1'b1;
                    end
                    `BTLA_MGT_ABORT_TASK, `BTLA_MGT_ABORT_SET,
                    `BTLA_MGT_LUN_RESET:
                    begin
                        flush_reg <= 1'b1;
                        dead <= 1'b0;
                    end
                    `BTLA_MGT_TARGET_RESET:
                    begin
                        flush_reg <= 1'b1;
                        dead <= 1'b0;
                        logged_in <= 1'b0;
                    end
                    `BTLA_MGT_STREAM, `BTLA_MGT_PASSWORD, `BTLA_MGT_CLEAR_SET:
                        mgt_status <= `BTLA_ST_UNSUPPORTED;
                    default:
                        mgt_status <= `BTLA_ST_UNSUPPORTED;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/btla_agent_sva.sv
// Assertion checker for the task list agent, bound to every agent instance
// Assumes btla_map.vh on the include path and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "btla_map.vh"
module btla_agent_sva #(
    parameter TAG_W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Task and management side
    input wire logic task_valid,
    input wire logic task_ready,
    input wire logic task_notify,
    input wire logic mgt_valid,
    input wire logic [3:0] mgt_function,
    input wire logic mgt_done,
    input wire logic [7:0] mgt_status,
    // Execution and status side
    input wire logic wr_exec_valid,
    input wire logic [TAG_W-1:0] wr_exec_tag,
    input wire logic wr_exec_done,
    input wire logic stat_valid,
    input wire logic stat_dir,
    input wire logic [1:0] stat_resp,
    input wire logic [7:0] stat_code,
    input wire logic logged_in,
    input wire logic dead,
    // Link and read side
    input wire logic fetch_link_enable,
    input wire logic rd_exec_valid,
    input wire logic [TAG_W-1:0] rd_exec_tag,
    input wire logic rd_exec_done
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence s_bad_take;
        task_valid && task_ready && !task_notify;
    endsequence
    sequence s_illegal_stat;
        stat_valid && stat_code == `BTLA_ST_ILLEGAL && stat_resp == `BTLA_RESP_ILLEGAL;
    endsequence

    a_ready_spaced: assert property (task_ready |=> !task_ready)
        else $error("task_ready high two cycles running");
    a_dead_refuse: assert property (dead && $past(dead) |-> !task_ready)
        else $error("task accepted while dead");
    a_login_gate: assert property (!logged_in && !$past(logged_in) |-> !task_ready)
        else $error("task accepted without login");
    a_notify_kill: assert property (s_bad_take |=> s_illegal_stat ##[0:2] dead)
        else $error("missing notify flag not failed");
    a_mgt_answer: assert property (mgt_valid |=> mgt_done)
        else $error("management request not answered");
    a_mgt_unsup: assert property (mgt_valid && (mgt_function == 4'h2 || mgt_function == 4'h4
        || mgt_function == 4'hD) |=> mgt_status == `BTLA_ST_UNSUPPORTED)
        else $error("unsupported function not reported");
    a_login_ok: assert property (mgt_valid && mgt_function == 4'h0 && !logged_in && !dead
        |=> logged_in && mgt_status == `BTLA_ST_OK)
        else $error("first login not granted");
    a_exec_hold: assert property (wr_exec_valid && !wr_exec_done && !mgt_valid && !$past(mgt_valid)
        && !dead |=> wr_exec_valid && $stable(wr_exec_tag))
        else $error("write command dropped before done");
    a_rd_hold: assert property (rd_exec_valid && !rd_exec_done && !mgt_valid && !$past(mgt_valid)
        && !dead |=> rd_exec_valid && $stable(rd_exec_tag))
        else $error("read command dropped before done");
    a_link_quiet: assert property (task_valid && task_ready |=> !fetch_link_enable)
        else $error("link pointer enabled after block queued");
    a_stat_follow: assert property (wr_exec_done |-> ##[1:6] (stat_valid && !stat_dir))
        else $error("write status missing after done");
endmodule
bind btla_agent btla_agent_sva #(.TAG_W(TAG_W)) u_btla_agent_sva (.clock(clock),
    .resetn(resetn), .task_valid(task_valid), .task_ready(task_ready),
    .task_notify(task_notify), .mgt_valid(mgt_valid), .mgt_function(mgt_function),
    .mgt_done(mgt_done), .mgt_status(mgt_status), .wr_exec_valid(wr_exec_valid),
    .wr_exec_tag(wr_exec_tag), .wr_exec_done(wr_exec_done), .stat_valid(stat_valid),
    .stat_dir(stat_dir), .stat_resp(stat_resp), .stat_code(stat_code),
    .logged_in(logged_in), .dead(dead), .fetch_link_enable(fetch_link_enable),
    .rd_exec_valid(rd_exec_valid), .rd_exec_tag(rd_exec_tag), .rd_exec_done(rd_exec_done));
`default_nettype wire

// >>> verification/btla_host_model.sv
// Initiator data side of one direction: finishes each active command
// Assumes exec_valid stays up until done; stall holds the transfer open
`timescale 1ns/1ps
`default_nettype none
module btla_host_model #(
    parameter DLY = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Command handshake
    input wire logic exec_valid,
    input wire logic stall,
    output var logic done
);
    int cnt;
    // Done only after the whole transfer, never twice for one command
    always @(posedge clock or negedge resetn)
        if (!resetn)
        begin
            cnt <= 0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (exec_valid && !done && !stall)
            begin
                cnt <= (cnt == DLY) ? 0 : cnt + 1;
                done <= (cnt == DLY);
            end
            else if (!exec_valid)
                cnt <= 0;
        end
endmodule
`default_nettype wire

// >>> verification/btla_agent_tb_top.sv
// Self-checking bench for the task list agent
// Assumes the agent, its FIFO, the checker and the host model are compiled
`timescale 1ns/1ps
`default_nettype none
module btla_agent_tb_top;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic bus_reset_pin = 1'b0;
    logic [7:0] rd_opcode = 8'h28;
    logic [7:0] rd_opmask = 8'hFF;
    logic [7:0] max_task_set = 8'h08;
    logic [24:0] max_units_wr = 25'h0000004;
    logic [24:0] max_units_rd = 25'h0000004;
    logic task_valid = 1'b0;
    logic [7:0] task_tag = 8'h00;
    logic [95:0] task_cdb = 96'h0;
    logic task_notify = 1'b1;
    logic [31:0] task_len = 32'h00000080;
    logic mgt_valid = 1'b0;
    logic [3:0] mgt_function = 4'h0;
    logic wr_stall = 1'b0;
    wire task_ready, fetch_link_enable, mgt_done, wr_exec_valid, wr_exec_done;
    wire rd_exec_valid, rd_exec_done, stat_valid, stat_dir, logged_in, dead;
    wire [7:0] mgt_status, wr_exec_tag, rd_exec_tag, stat_tag, stat_code;
    wire [1:0] stat_resp;
    int miscompares = 0;
    int n_checks = 0;
    logic [18:0] stq[$];
    logic ok;

    always #12.5 clock = ~clock;

    btla_agent #(.RECON_CYCLES(20)) u_btla_agent (.clock(clock), .resetn(resetn),
        .bus_reset_pin(bus_reset_pin), .rd_opcode(rd_opcode), .rd_opmask(rd_opmask),
        .max_task_set(max_task_set), .max_units_wr(max_units_wr),
        .max_units_rd(max_units_rd), .task_valid(task_valid), .task_ready(task_ready),
        .task_tag(task_tag), .task_cdb(task_cdb), .task_notify(task_notify),
        .task_len(task_len), .fetch_link_enable(fetch_link_enable),
        .mgt_valid(mgt_valid), .mgt_function(mgt_function), .mgt_tag(8'h00),
        .mgt_done(mgt_done), .mgt_status(mgt_status), .wr_exec_valid(wr_exec_valid),
        .wr_exec_tag(wr_exec_tag), .wr_exec_done(wr_exec_done),
        .rd_exec_valid(rd_exec_valid), .rd_exec_tag(rd_exec_tag),
        .rd_exec_done(rd_exec_done), .stat_valid(stat_valid), .stat_dir(stat_dir),
        .stat_tag(stat_tag), .stat_resp(stat_resp), .stat_code(stat_code),
        .logged_in(logged_in), .dead(dead));
    btla_host_model #(.DLY(8)) u_host_wr (.clock(clock), .resetn(resetn),
        .exec_valid(wr_exec_valid), .stall(wr_stall), .done(wr_exec_done));
    btla_host_model #(.DLY(1)) u_host_rd (.clock(clock), .resetn(resetn),
        .exec_valid(rd_exec_valid), .stall(1'b0), .done(rd_exec_done));

    always @(posedge clock)
        if (stat_valid === 1'b1)
            stq.push_back({stat_dir, stat_resp, stat_code, stat_tag});

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic mgt(input logic [3:0] f, input logic [7:0] e);
        @(posedge clock);
        #1;
        mgt_function = f;
        mgt_valid = 1'b1;
        @(posedge clock);
        #1;
        mgt_valid = 1'b0;
        chk("mgt answer", {23'h0, 1'b1, e}, {23'h0, mgt_done, mgt_status});
    endtask

    task automatic put(input logic [7:0] t, input logic [7:0] op, input logic nf,
        input logic [31:0] ln, input int lim);
        int k;
        k = 0;
        @(posedge clock);
        #1;
        task_tag = t;
        task_cdb = {op, 88'h0};
        task_notify = nf;
        task_len = ln;
        task_valid = 1'b1;
        while (task_ready !== 1'b1 && k < lim)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        ok = (k < lim);
        if (ok)
            @(posedge clock);
        #1;
        task_valid = 1'b0;
    endtask

    task automatic stat(input logic [18:0] e);
        int k;
        logic [18:0] g;
        k = 0;
        g = '1;
        while (stq.size() == 0 && k < 40)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        if (stq.size() > 0)
            g = stq.pop_front();
        chk("status", {13'h0, e}, {13'h0, g});
    endtask

    task automatic s_login;
        mgt(4'h0, 8'h00);
        mgt(4'h0, 8'h02);
        chk("logged_in", 32'h1, {31'h0, logged_in});
    endtask

    task automatic s_codes;
        logic [3:0] f[3] = '{4'h2, 4'h4, 4'hD};
        foreach (f[i])
            mgt(f[i], 8'h01);
        mgt(4'h1, 8'h00);
    endtask

    task automatic s_order;
        put(8'h01, 8'h2A, 1'b1, 32'h00000080, 50);
        put(8'h02, 8'h28, 1'b1, 32'h00000080, 50);
        put(8'h03, 8'h0A, 1'b1, 32'h00000080, 50);
        stat({1'b1, 2'h0, 8'h00, 8'h02});
        stat({1'b0, 2'h0, 8'h00, 8'h01});
        stat({1'b0, 2'h0, 8'h00, 8'h03});
        rd_opmask = 8'hF0;
        put(8'h05, 8'h21, 1'b1, 32'h00000080, 50);
        stat({1'b1, 2'h0, 8'h00, 8'h05});
        rd_opmask = 8'hFF;
    endtask

    task automatic s_limit;
        max_task_set = 8'h03;
        wr_stall = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            put(8'h10 + i[7:0], 8'h2A, 1'b1, 32'h00000080, 20);
            chk("accepted", {31'h0, i < 3}, {31'h0, ok});
        end
        wr_stall = 1'b0;
        for (int i = 0; i < 3; i++)
            stat({1'b0, 2'h0, 8'h00, 8'h10 + i[7:0]});
        max_task_set = 8'h08;
    endtask

    task automatic s_size;
        put(8'h20, 8'h2A, 1'b1, 32'h00000200, 50);
        stat({1'b0, 2'h0, 8'h00, 8'h20});
        put(8'h21, 8'h28, 1'b1, 32'h00000201, 50);
        stat({1'b1, 2'h2, 8'hFF, 8'h21});
        chk("dead", 32'h0, {31'h0, dead});
    endtask

    task automatic s_notify;
        put(8'h30, 8'h2A, 1'b0, 32'h00000080, 50);
        stat({1'b0, 2'h2, 8'hFF, 8'h30});
        chk("dead", 32'h1, {31'h0, dead});
        put(8'h31, 8'h2A, 1'b1, 32'h00000080, 10);
        chk("accepted", 32'h0, {31'h0, ok});
        mgt(4'hC, 8'h00);
        chk("dead", 32'h0, {31'h0, dead});
    endtask

    task automatic s_recon;
        @(posedge clock);
        #1;
        bus_reset_pin = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        bus_reset_pin = 1'b0;
        repeat (5) @(posedge clock);
        mgt(4'h3, 8'h00);
        repeat (30) @(posedge clock);
        chk("logged_in", 32'h1, {31'h0, logged_in});
        mgt(4'h7, 8'h00);
        chk("logged_in", 32'h0, {31'h0, logged_in});
        put(8'h40, 8'h2A, 1'b1, 32'h00000080, 10);
        chk("accepted", 32'h0, {31'h0, ok});
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #(25 * 5000);
        miscompares++;
        $display("[ERR] run time expected done seen hung");
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge clock);
        #1;
        resetn = 1'b1;
        repeat (2) @(posedge clock);
        s_login();
        s_codes();
        s_order();
        s_limit();
        s_size();
        s_notify();
        s_recon();
        complete_run();
    end
endmodule
`default_nettype wire
